/* rtl/bec_map.svh */
`ifndef BEC_MAP_SVH
`define BEC_MAP_SVH

// Register byte offsets on the APB bus
`define BEC_OFF_CTRL       8'h00
`define BEC_OFF_CODE       8'h04
`define BEC_OFF_DIAG       8'h08
`define BEC_OFF_STAT       8'h0C
`define BEC_OFF_ISTAT      8'h10
`define BEC_OFF_IMASK      8'h14
`define BEC_OFF_LEN        8'h18

// Field positions
`define BEC_CTRL_START     0
`define BEC_CTRL_KIND      1
`define BEC_DIAG_MT_LSB    0
`define BEC_DIAG_IE_LSB    8
`define BEC_STAT_BUSY      0
`define BEC_STAT_KIND      1
`define BEC_INT_DONE       0
`define BEC_INT_REFUSED    1
`define BEC_EXT_BIT        7

// Reset values
`define BEC_RST_CODE       7'h00
`define BEC_RST_DIAG       16'h0000
`define BEC_RST_INT        2'h0
`define BEC_RST_LEN        3'h0

// Element identifier and octet positions
`define BEC_PERR_IDENT     8'h45
`define BEC_OCT_IDENT      3'h0
`define BEC_OCT_LEN        3'h1
`define BEC_OCT_CODE       3'h2
`define BEC_OCT_DIAG_MT    3'h3
`define BEC_OCT_DIAG_IE    3'h4
`define BEC_HDR_OCTETS     3'h2
`define BEC_BASE_OCTETS    3'h3

// Protocol error cause codes
`define BEC_CAUSE_DISC     7'h01
`define BEC_CAUSE_MSGTYPE  7'h04
`define BEC_CAUSE_OOS      7'h05
`define BEC_CAUSE_REPOPT   7'h06
`define BEC_CAUSE_MISSMAND 7'h07
`define BEC_CAUSE_UNRECIE  7'h08
`define BEC_CAUSE_MANDCONT 7'h09
`define BEC_CAUSE_OPTCONT  7'h0A
`define BEC_CAUSE_INCOMPAT 7'h0B
`define BEC_CAUSE_REPMAND  7'h0C
`define BEC_CAUSE_TOOMANY  7'h0D
`define BEC_CAUSE_REFNUM   7'h0F

// Connection incomplete reason codes
`define BEC_RSN_NORMAL     7'h00
`define BEC_RSN_FAULT      7'h01
`define BEC_RSN_NOPROV     7'h02
`define BEC_RSN_BADSLOT    7'h03
`define BEC_RSN_BADLINK    7'h04
`define BEC_RSN_CCHAN      7'h05

// Diagnostic length classes
`define BEC_DIAG_NONE      2'd0
`define BEC_DIAG_ONE       2'd1
`define BEC_DIAG_TWO       2'd2
`define BEC_DIAG_BAD       2'd3

`endif

/* rtl/bec_pkg.sv */
package bec_pkg;

   // Element kind selected by software
   typedef enum logic {
      BEC_KIND_PERR = 1'b0,
      BEC_KIND_CINC = 1'b1
   } bec_kind_t;

   // Builder states, Gray coded along idle-load-fetch-catch-emit
   typedef enum logic [2:0] {
      BEC_ST_IDLE  = 3'b000,
      BEC_ST_LOAD  = 3'b001,
      BEC_ST_FETCH = 3'b011,
      BEC_ST_CATCH = 3'b010,
      BEC_ST_EMIT  = 3'b110
   } bec_state_t;

endpackage

/* rtl/bec_octet_mem.sv */
`timescale 1ns/10ps

module bec_octet_mem #(
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data
);

   logic [7:0] mem [DEPTH];

   // Octet store, written while an element is assembled
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read port, one cycle of latency
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

/* rtl/bec_codec.sv */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "bec_map.svh"

module bec_codec #(
   parameter logic [7:0] CINC_IDENT = 8'h00,
   parameter int         MEM_DEPTH  = 8
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   output logic             tx_last,
   input  wire logic        tx_ready,
   output logic             irq,
   output bec_pkg::bec_kind_t tx_kind
);

   import bec_pkg::*;

   localparam int IW = 3;

   // Diagnostic length class of a cause code
   function automatic logic [1:0] diag_len(input logic [6:0] cause);
      logic [1:0] r;
      r = `BEC_DIAG_BAD;
      case (cause)
         `BEC_CAUSE_DISC,
         `BEC_CAUSE_REFNUM:   r = `BEC_DIAG_NONE;
         `BEC_CAUSE_MSGTYPE,
         `BEC_CAUSE_INCOMPAT,
         `BEC_CAUSE_TOOMANY:  r = `BEC_DIAG_ONE;
         `BEC_CAUSE_OOS,
         `BEC_CAUSE_REPOPT,
         `BEC_CAUSE_MISSMAND,
         `BEC_CAUSE_UNRECIE,
         `BEC_CAUSE_MANDCONT,
         `BEC_CAUSE_OPTCONT,
         `BEC_CAUSE_REPMAND:  r = `BEC_DIAG_TWO;
         default:             r = `BEC_DIAG_BAD;
      endcase
      return r;
   endfunction

   // Defined reason codes of the connection incomplete element
   function automatic logic reason_ok(input logic [6:0] reason);
      logic ok;
      ok = 1'b0;
      case (reason)
         `BEC_RSN_NORMAL,
         `BEC_RSN_FAULT,
         `BEC_RSN_NOPROV:   ok = 1'b1;
         `BEC_RSN_BADSLOT,
         `BEC_RSN_BADLINK,
         `BEC_RSN_CCHAN:    ok = 1'b1;
         default:           ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Whether a code may be sent for the given kind
   function automatic logic code_ok(input bec_kind_t kind, input logic [6:0] code);
      logic ok;
      ok = 1'b0;
      if (kind == BEC_KIND_PERR) begin
         ok = (diag_len(code) != `BEC_DIAG_BAD);
      end else begin
         ok = reason_ok(code);
      end
      return ok;
   endfunction

   // Total octets of an element
   function automatic logic [IW-1:0] elem_len(input bec_kind_t kind,
                                              input logic [6:0] code);
      logic [IW-1:0] n;
      n = `BEC_BASE_OCTETS;
      if (kind == BEC_KIND_PERR) begin
         n = `BEC_BASE_OCTETS + {1'b0, diag_len(code)};
      end else begin
         n = `BEC_BASE_OCTETS;
      end
      return n;
   endfunction

   // Octet at a given position of the element
   function automatic logic [7:0] octet_at(input logic [IW-1:0] idx,
                                           input bec_kind_t kind,
                                           input logic [6:0] code,
                                           input logic [6:0] mt,
                                           input logic [6:0] ie);
      logic [7:0] o;
      logic [IW-1:0] clen;
      o = 8'h00;
      clen = elem_len(kind, code) - `BEC_HDR_OCTETS;
      case (idx)
         `BEC_OCT_IDENT:   o = (kind == BEC_KIND_PERR) ? `BEC_PERR_IDENT
                                                       : CINC_IDENT;
         `BEC_OCT_LEN:     o = {5'h00, clen};
         `BEC_OCT_CODE:    o = {1'b1, code};
         `BEC_OCT_DIAG_MT: o = {1'b0, mt};
         `BEC_OCT_DIAG_IE: o = {1'b0, ie};
         default:          o = 8'h00;
      endcase
      return o;
   endfunction

   // Software-visible registers
   logic [6:0]   code_reg;
   logic [15:0]  diag_reg;
   logic [1:0]   istat;
   logic [1:0]   imask;
   logic [IW-1:0] last_len;

   // Job captured at start
   bec_state_t   state;
   bec_kind_t    job_kind;
   logic [6:0]   job_code;
   logic [6:0]   job_mt;
   logic [6:0]   job_ie;
   logic [IW-1:0] job_len;
   logic [IW-1:0] idx;

   // APB decode
   logic         acc_first;
   logic         acc_done;
   logic         wr_done;
   logic         start_req;
   logic         start_ok;
   logic         start_ok_q;
   logic         mapped;
   logic [31:0]  rd_mux;
   bec_kind_t    req_kind;

   // Builder events
   logic         ev_done;
   logic         ev_refused;
   logic         mem_wr_en;
   logic [7:0]   mem_wr_data;
   logic [7:0]   mem_rd_data;

   assign acc_first = psel && penable && !pready;
   assign acc_done  = psel && penable && pready;
   assign wr_done   = acc_done && pwrite;
   assign req_kind  = bec_kind_t'(pwdata[`BEC_CTRL_KIND]);
   assign start_req = pwrite && (paddr == `BEC_OFF_CTRL) && pwdata[`BEC_CTRL_START];
   assign start_ok  = (state == BEC_ST_IDLE) && code_ok(req_kind, code_reg);

   // Address decode
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `BEC_OFF_CTRL:  rd_mux = 32'h0000_0000;
         `BEC_OFF_CODE:  rd_mux = {25'h0, code_reg};
         `BEC_OFF_DIAG:  rd_mux = {16'h0, diag_reg};
         `BEC_OFF_STAT:  rd_mux = {30'h0, job_kind, (state != BEC_ST_IDLE)};
         `BEC_OFF_ISTAT: rd_mux = {30'h0, istat};
         `BEC_OFF_IMASK: rd_mux = {30'h0, imask};
         `BEC_OFF_LEN:   rd_mux = {29'h0, last_len};
         default: begin
            mapped = 1'b0;
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // APB answer, one wait cycle per access
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h0000_0000;
         start_ok_q <= 1'b0;
      end else if (acc_first) begin
         pready     <= 1'b1;
         prdata     <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr    <= !mapped || (start_req && !start_ok);
         start_ok_q <= start_req && start_ok;
      end else begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         start_ok_q <= 1'b0;
      end
   end

   // Refused start: busy or a reserved code
   assign ev_refused = wr_done && start_req && !start_ok_q;

   // Code and diagnostic registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         code_reg <= `BEC_RST_CODE;
         diag_reg <= `BEC_RST_DIAG;
      end else if (wr_done) begin
         if (paddr == `BEC_OFF_CODE) begin
            code_reg <= pwdata[6:0];
         end
         if (paddr == `BEC_OFF_DIAG) begin
            diag_reg <= pwdata[15:0];
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         imask <= `BEC_RST_INT;
      end else if (wr_done && (paddr == `BEC_OFF_IMASK)) begin
         imask <= pwdata[1:0];
      end
   end

   // Sticky status, write one to clear, a new event wins
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         istat <= `BEC_RST_INT;
      end else begin
         if (wr_done && (paddr == `BEC_OFF_ISTAT)) begin
            istat[`BEC_INT_DONE]    <= ev_done || (istat[`BEC_INT_DONE]
                                       && !pwdata[`BEC_INT_DONE]);
            istat[`BEC_INT_REFUSED] <= ev_refused || (istat[`BEC_INT_REFUSED]
                                       && !pwdata[`BEC_INT_REFUSED]);
         end else begin
            istat[`BEC_INT_DONE]    <= istat[`BEC_INT_DONE] || ev_done;
            istat[`BEC_INT_REFUSED] <= istat[`BEC_INT_REFUSED] || ev_refused;
         end
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat & imask);
      end
   end

   // Builder: capture a job, load its octets, then walk them out
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state    <= BEC_ST_IDLE;
         job_kind <= BEC_KIND_PERR;
         job_code <= `BEC_RST_CODE;
         job_mt   <= 7'h00;
         job_ie   <= 7'h00;
         job_len  <= `BEC_RST_LEN;
         last_len <= `BEC_RST_LEN;
         idx      <= '0;
      end else begin
         case (state)
            BEC_ST_IDLE: begin
               if (wr_done && start_req && start_ok_q) begin
                  job_kind <= req_kind;
                  job_code <= code_reg;
                  job_mt   <= diag_reg[`BEC_DIAG_MT_LSB +: 7];
                  job_ie   <= diag_reg[`BEC_DIAG_IE_LSB +: 7];
                  job_len  <= elem_len(req_kind, code_reg);
                  last_len <= elem_len(req_kind, code_reg);
                  idx      <= '0;
                  state    <= BEC_ST_LOAD;
               end
            end
            BEC_ST_LOAD: begin
               if (idx == job_len - 3'd1) begin
                  idx   <= '0;
                  state <= BEC_ST_FETCH;
               end else begin
                  idx <= idx + 3'd1;
               end
            end
            BEC_ST_FETCH: begin
               state <= BEC_ST_CATCH;
            end
            BEC_ST_CATCH: begin
               state <= BEC_ST_EMIT;
            end
            BEC_ST_EMIT: begin
               if (tx_ready) begin
                  if (idx == job_len - 3'd1) begin
                     state <= BEC_ST_IDLE;
                  end else begin
                     idx   <= idx + 3'd1;
                     state <= BEC_ST_FETCH;
                  end
               end
            end
            default: begin
               state <= BEC_ST_IDLE;
            end
         endcase
      end
   end

   // Element finished when its last octet is taken
   assign ev_done     = (state == BEC_ST_EMIT) && tx_ready && (idx == job_len - 3'd1);
   assign mem_wr_en   = (state == BEC_ST_LOAD);
   assign mem_wr_data = octet_at(idx, job_kind, job_code, job_mt, job_ie);

   // Octet store
   bec_octet_mem #(
      .DEPTH (MEM_DEPTH),
      .AW    (IW)
   ) u_mem (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .wr_en   (mem_wr_en),
      .wr_addr (idx),
      .wr_data (mem_wr_data),
      .rd_addr (idx),
      .rd_data (mem_rd_data)
   );

   // Octet stream output, held until taken
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
         tx_last  <= 1'b0;
         tx_kind  <= BEC_KIND_PERR;
      end else if (state == BEC_ST_CATCH) begin
         tx_valid <= 1'b1;
         tx_data  <= mem_rd_data;
         tx_last  <= (idx == job_len - 3'd1);
         tx_kind  <= job_kind;
      end else if ((state == BEC_ST_EMIT) && tx_ready) begin
         tx_valid <= 1'b0;
         tx_last  <= 1'b0;
      end
   end

endmodule

/* tb/bec_codec_checker.sv */
`timescale 1ns/10ps
module bec_codec_checker (
   input wire logic               sys_clk,
   input wire logic               resetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               tx_valid,
   input wire logic [7:0]         tx_data,
   input wire logic               tx_last,
   input wire logic               tx_ready,
   input wire bec_pkg::bec_kind_t tx_kind
);
   import bec_pkg::*;
   logic [2:0] idx;
   logic [2:0] elen;
   logic       perr;
   logic       cinc;
   // Octet position in the element and its length octet
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         idx <= 3'h0;
         elen <= 3'h0;
      end else if (tx_valid && tx_ready) begin
         idx <= tx_last ? 3'h0 : idx + 3'h1;
         if (idx == 3'h1) elen <= tx_data[2:0];
      end
   end
   assign perr = tx_valid && (tx_kind == BEC_KIND_PERR);
   assign cinc = tx_valid && (tx_kind == BEC_KIND_CINC);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_stall;
      tx_valid && !tx_ready;
   endsequence
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   a_ident_first: assert property (perr && idx == 3'h0 |-> tx_data == 8'h45)
      else $error("wrong identifier octet");
   a_len_range: assert property (perr && idx == 3'h1 |-> tx_data inside {8'h01, 8'h02, 8'h03})
      else $error("length octet out of range");
   a_last_at_len: assert property (tx_valid && idx >= 3'h2 |-> tx_last == (idx == elen + 3'h1))
      else $error("last flag off the length");
   a_cause_legal: assert property (perr && idx == 3'h2 |-> tx_data[6:0] inside
      {7'h01, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0F})
      else $error("reserved cause sent");
   a_no_diag: assert property (perr && idx == 3'h2 && tx_data[6:0] inside {7'h01, 7'h0F}
      |-> elen == 3'h1)
      else $error("diagnostic on a bare cause");
   a_one_diag: assert property (perr && idx == 3'h2 && tx_data[6:0] inside {7'h04, 7'h0B, 7'h0D}
      |-> elen == 3'h2)
      else $error("one octet diagnostic expected");
   a_two_diag: assert property (perr && idx == 3'h2 && tx_data[6:0] inside
      {7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0C} |-> elen == 3'h3)
      else $error("two octet diagnostic expected");
   a_ext_bits: assert property (tx_valid && idx == 3'h2 |-> tx_data[7])
      else $error("code octet bit 8 clear");
   a_diag_bit: assert property (tx_valid && idx >= 3'h3 |-> !tx_data[7])
      else $error("diagnostic octet bit 8 set");
   a_cinc_shape: assert property (cinc && idx == 3'h1 |-> tx_data == 8'h01 ##0 !tx_last)
      else $error("bad incomplete length");
   a_reason_legal: assert property (cinc && idx == 3'h2 |-> tx_data[6:0] <= 7'h05 && tx_last)
      else $error("bad reason octet");
   a_hold_offer: assert property (s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("offer dropped before taken");
   a_ready_wait: assert property (s_wait |=> pready)
      else $error("no answer after one wait state");
endmodule

bind bec_codec bec_codec_checker i_chk (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pready(pready), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_last(tx_last), .tx_ready(tx_ready), .tx_kind(tx_kind));

/* tb/bec_exchange_model.sv */
`timescale 1ns/10ps
module bec_exchange_model (
   input wire logic               sys_clk,
   input wire logic               resetn,
   input wire logic               tx_valid,
   input wire logic [7:0]         tx_data,
   input wire logic               tx_last,
   input wire bec_pkg::bec_kind_t tx_kind,
   input wire logic               slow,
   output logic                   tx_ready,
   output logic [39:0]            elem,
   output logic [2:0]             elem_len,
   output logic [7:0]             elem_cnt,
   output logic                   bad_len
);
   import bec_pkg::*;
   logic [2:0] pos;
   // Length octet allowed for a cause or reason, FF when reserved
   function automatic logic [7:0] want(input logic k, input logic [6:0] c);
      if (k) return (c <= 7'h05) ? 8'h01 : 8'hFF;
      case (c)
         7'h01, 7'h0F: return 8'h01;
         7'h04, 7'h0B, 7'h0D: return 8'h02;
         7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0C: return 8'h03;
         default: return 8'hFF;
      endcase
   endfunction
   // Sink takes every octet, or every other cycle when slow
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) tx_ready <= 1'b0;
      else tx_ready <= !slow || !tx_ready;
   end
   // Collect octets and check lengths against the code
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pos <= 3'h0;
         elem <= 40'h0;
         elem_len <= 3'h0;
         elem_cnt <= 8'h0;
         bad_len <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         elem[39 - 8 * pos -: 8] <= tx_data;
         if (pos == 3'h2 && elem[31:24] != want(tx_kind == BEC_KIND_CINC, tx_data[6:0]))
            bad_len <= 1'b1;
         if (tx_last && {5'h0, pos} != elem[31:24] + 8'h1) bad_len <= 1'b1;
         if (tx_last) begin
            pos <= 3'h0;
            elem_len <= pos + 3'h1;
            elem_cnt <= elem_cnt + 8'h1;
         end else begin
            pos <= pos + 3'h1;
         end
      end
   end
endmodule

/* tb/bearer_error_ie_codec_test.sv */
`timescale 1ns/10ps
`include "bec_map.svh"
module bearer_error_ie_codec_test;
   import bec_pkg::*;
   localparam logic [7:0] CINC_ID = 8'h5A; // Arbitrary identifier value
   logic        sys_clk, resetn, psel, penable, pwrite, slow, pready, pslverr;
   logic        tx_valid, tx_last, tx_ready, irq, bad_len, err;
   logic [7:0]  paddr, tx_data, elem_cnt;
   logic [31:0] pwdata, prdata, rd;
   logic [39:0] elem;
   logic [2:0]  elem_len;
   bec_kind_t   tx_kind;
   int          fail_count, n_checks;
   logic [6:0]  cz [12] = '{7'h01, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h0B,
                           7'h0C, 7'h0D, 7'h0F};
   logic [2:0]  nz [12] = '{3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h5, 3'h4, 3'h3};
   logic [6:0]  rz [4] = '{7'h00, 7'h02, 7'h0E, 7'h7F};

   bec_codec #(.CINC_IDENT(CINC_ID)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready), .irq(irq), .tx_kind(tx_kind));
   bec_exchange_model i_far (.sys_clk(sys_clk), .resetn(resetn), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_kind(tx_kind), .slow(slow),
      .tx_ready(tx_ready), .elem(elem), .elem_len(elem_len), .elem_cnt(elem_cnt),
      .bad_len(bad_len));

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Verdict and end of run
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data and error taken at the pready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         close_out();
      end
   endtask

   // Build one element and compare what the far side got
   task run(input logic k, input logic [6:0] c, input logic [2:0] n, input logic [7:0] id,
            input logic dbl);
      int t;
      logic [7:0] c0;
      c0 = elem_cnt;
      apb(1'b1, `BEC_OFF_CODE, {25'h0, c});
      apb(1'b1, `BEC_OFF_CTRL, {30'h0, k, 1'b1});
      chk(err, 1'b0);
      if (dbl) apb(1'b1, `BEC_OFF_CTRL, {30'h0, k, 1'b1});
      if (dbl) chk(err, 1'b1);
      if (dbl) apb(1'b0, `BEC_OFF_STAT, 32'h0);
      if (dbl) chk(rd, {30'h0, k, 1'b1});
      t = 0;
      while (elem_cnt == c0 && t < 400) begin
         @(posedge sys_clk);
         t++;
      end
      if (t >= 400) begin
         fail_count++;
         close_out();
      end
      chk(elem_len, n);
      chk(elem[39:32], id);
      chk(elem[31:24], n - 3'h2);
      chk(elem[23:16], {1'b1, c});
      if (n > 3'h3) chk(elem[15:8], 8'h35);
      if (n > 3'h4) chk(elem[7:0], 8'h23);
      apb(1'b0, `BEC_OFF_LEN, 32'h0);
      chk(rd, n);
      apb(1'b0, `BEC_OFF_STAT, 32'h0);
      chk(rd, {30'h0, k, 1'b0});
      apb(1'b0, `BEC_OFF_ISTAT, 32'h0);
      chk(rd, {dbl, 1'b1});
      chk(irq, 1'b1);
      apb(1'b1, `BEC_OFF_ISTAT, 32'h3);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0);
   endtask

   // Reserved code: refused, flagged, nothing sent
   task refuse(input logic k, input logic [6:0] c);
      logic [7:0] c0;
      c0 = elem_cnt;
      apb(1'b1, `BEC_OFF_CODE, {25'h0, c});
      apb(1'b1, `BEC_OFF_CTRL, {30'h0, k, 1'b1});
      chk(err, 1'b1);
      apb(1'b0, `BEC_OFF_ISTAT, 32'h0);
      chk(rd, 32'h2);
      chk(irq, 1'b0);
      apb(1'b1, `BEC_OFF_ISTAT, 32'h2);
      chk(elem_cnt, c0);
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 1'b0;
      fail_count = 0;
      n_checks = 0;
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int a = 0; a <= 24; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, `BEC_OFF_DIAG, 32'h0000A3B5);
      apb(1'b0, `BEC_OFF_DIAG, 32'h0);
      chk(rd, 32'h0000A3B5);
      foreach (rz[i]) refuse(1'b0, rz[i]);
      refuse(1'b1, 7'h06);
      apb(1'b1, `BEC_OFF_IMASK, 32'h3);
      apb(1'b0, `BEC_OFF_IMASK, 32'h0);
      chk(rd, 32'h3);
      foreach (cz[i]) begin
         slow <= i[0];
         run(1'b0, cz[i], nz[i], 8'h45, i == 0);
      end
      for (int r = 0; r < 6; r++) run(1'b1, r[6:0], 3'h3, CINC_ID, 1'b0);
      chk(bad_len, 1'b0);
      close_out();
   end
endmodule
